// ### ucrm_top.sv
// Register bank and address decoder of one UART channel
`timescale 1ns/100ps
// Notes on behaviour
// - Address 0 with divisor enable clear: read receive byte, write transmit byte.
// - Divisor enable set and line control not BF: addresses 0,1 are divisor bytes.
// - Fraction divisor at 2 needs divisor enable, not BF, and enhanced bit 4.
// - Divisor enable clear: address 2 reads interrupt status, writes FIFO control.
// - FIFO control: enable, rx reset, tx reset, DMA, tx trigger, rx trigger.
// - Interrupt enable at 1: rx, tx empty, line, modem, sleep, stop, RTS, CTS.
// - Extended bits writable and effective only with enhanced bit 4; else zero.
// - Line control at 3: length, stop, parity enable, even, forced, break, divisor.
// - Modem control at 4: DTR, RTS, HALT_RESUME_LEVELS/FIFO_TRIGGER_LEVELS enable, output 2, loopback.
// - Upper modem control: resume on any char, infrared on B only, prescaler.
// - Line status at 5 is read-only status from the core.
// - Modem status at 6: change flags low nibble, input levels high nibble.
// - Address 7 is normally a free scratch byte.
// - Address 6 may hold halt and resume thresholds.
// - Address 7 may hold transmit and receive trigger levels.
// - Addresses 8 and 9 return FIFO space and fill, bit 7 zero.
// - Address A holds the pin direction byte.
// - Addresses B and C hold pin state and pin interrupt enable, divisor clear.
// - Addresses E and F hold pin control and extra features, read/write.
// - Line control BF: 2 is enhanced function, 4 to 7 resume/stop characters.
module ucrm_top #(
   parameter bit IS_CHANNEL_B = 1'b0
) (
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic [3:0] i_addr,
   input wire logic i_wr,
   input wire logic i_rd,
   input wire logic [7:0] i_wdata,
   output logic [7:0] o_rdata,
   input wire logic [7:0] i_rx_data,
   output logic o_rx_pop,
   output logic o_tx_load,
   output logic [7:0] o_tx_data,
   input wire logic [5:0] i_int_source,
   input wire logic [7:0] i_line_status,
   input wire logic [6:0] i_tx_space,
   input wire logic [6:0] i_rx_fill,
   input wire logic i_cts_n,
   input wire logic i_dsr_n,
   input wire logic i_ring_in_n,
   input wire logic i_carrier_detect_in_n,
   input wire logic [7:0] i_gpio_in,
   output logic [7:0] o_gpio_out,
   output logic [7:0] o_gpio_oe,
   output logic o_fifo_write,
   output logic [7:0] o_fifo_ctrl,
   output logic [7:0] o_int_enable,
   output logic [7:0] o_line_control,
   output logic [7:0] o_modem_control,
   output logic [7:0] o_divisor_low,
   output logic [7:0] o_divisor_high,
   output logic [7:0] o_divisor_fraction,
   output logic [7:0] o_enhanced_function,
   output logic [7:0] o_resume_char1,
   output logic [7:0] o_resume_char2,
   output logic [7:0] o_stop_char1,
   output logic [7:0] o_stop_char2,
   output logic [7:0] o_halt_resume_levels,
   output logic [7:0] o_fifo_trigger_levels,
   output logic [7:0] o_pin_interrupt_enable,
   output logic [7:0] o_pin_control,
   output logic [7:0] o_extra_features
);
   logic rst_s1;
   logic rst_sync;
   ucrm_pkg::ucrm_state_s st;
   ucrm_pkg::ucrm_state_s next_st;
   logic bank_enh;
   logic bank_div;
   logic bank_norm;
   logic ext_on;
   logic alt_67;
   logic [7:0] ext_keep;
   logic [7:0] mctl_keep;
   logic [7:0] pin_view;
   logic [7:0] read_val;
   logic msr_read;

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         rst_s1 <= 1'b0;
         rst_sync <= 1'b0;
      end else begin
         rst_s1 <= 1'b1;
         rst_sync <= rst_s1;
      end
   end

   always_comb begin
      bank_enh = (st.lctl == ucrm_pkg::LCTL_ENHANCED);
      bank_div = st.lctl[ucrm_pkg::LCTL_DIV_EN] && !bank_enh;
      bank_norm = !st.lctl[ucrm_pkg::LCTL_DIV_EN];
      ext_on = st.efn[ucrm_pkg::EFN_EXT_EN];
      alt_67 = st.mctl[ucrm_pkg::MCTL_TCR_EN];
      pin_view = (st.g_s2 & ~st.pin_dir) | (st.pin_out & st.pin_dir);
   end

   // Read decode across the overlaid banks
   always_comb begin
      read_val = ucrm_pkg::RESET_BYTE;
      msr_read = 1'b0;
      unique case (i_addr)
         ucrm_pkg::ADDR_HOLD: begin
            if (bank_norm) begin
               read_val = i_rx_data;
            end else if (bank_div) begin
               read_val = st.div_lo;
            end
         end
         ucrm_pkg::ADDR_IEN: begin
            if (bank_norm) begin
               read_val = st.ien;
            end else if (bank_div) begin
               read_val = st.div_hi;
            end
         end
         ucrm_pkg::ADDR_ISTAT: begin
            if (bank_enh) begin
               read_val = st.efn;
            end else if (bank_norm) begin
               read_val = {{2{st.fctl[ucrm_pkg::FCTL_FIFO_EN]}}, 2'b00, i_int_source[3:0]};
               if (ext_on) begin
                  read_val[5:4] = i_int_source[5:4];
               end
            end else if (ext_on) begin
               read_val = st.div_fr;
            end
         end
         ucrm_pkg::ADDR_LCTL: read_val = st.lctl;
         ucrm_pkg::ADDR_MCTL: read_val = bank_enh ? st.resume1 : st.mctl;
         ucrm_pkg::ADDR_LSTAT: read_val = bank_enh ? st.resume2 : i_line_status;
         ucrm_pkg::ADDR_MSTAT: begin
            if (bank_enh) begin
               read_val = st.stop1;
            end else if (alt_67) begin
               read_val = st.halt_lv;
            end else begin
               read_val = {st.m_s2, st.delta};
               msr_read = i_rd;
            end
         end
         ucrm_pkg::ADDR_SCRATCH: begin
            if (bank_enh) begin
               read_val = st.stop2;
            end else begin
               read_val = alt_67 ? st.trig_lv : st.scratch;
            end
         end
         ucrm_pkg::ADDR_TXSPACE: read_val = {1'b0, i_tx_space};
         ucrm_pkg::ADDR_RXFILL: read_val = {1'b0, i_rx_fill};
         ucrm_pkg::ADDR_PINDIR: read_val = st.pin_dir;
         ucrm_pkg::ADDR_PINSTATE: read_val = bank_norm ? pin_view : ucrm_pkg::RESET_BYTE;
         ucrm_pkg::ADDR_PININT: read_val = bank_norm ? st.pin_ien : ucrm_pkg::RESET_BYTE;
         ucrm_pkg::ADDR_RSVD: read_val = ucrm_pkg::RESET_BYTE;
         ucrm_pkg::ADDR_PINCTL: read_val = st.pin_ctl;
         ucrm_pkg::ADDR_EXTRA: read_val = st.extra;
      endcase
   end

   // Next state: writes, pulses, synchronisers and change flags
   always_comb begin
      next_st = st;
      next_st.rx_pop = i_rd && (i_addr == ucrm_pkg::ADDR_HOLD) && bank_norm;
      next_st.tx_load = 1'b0;
      next_st.fifo_write = 1'b0;
      // Held as asserted-high so the cleared reset state matches idle pins
      next_st.m_s1 = {~i_carrier_detect_in_n, ~i_ring_in_n, ~i_dsr_n, ~i_cts_n};
      next_st.m_s2 = st.m_s1;
      next_st.m_s3 = st.m_s2;
      next_st.g_s1 = i_gpio_in;
      next_st.g_s2 = st.g_s1;
      if (i_rd) begin
         next_st.rdata = read_val;
      end
      // A change seen in the read cycle survives the clear
      next_st.delta = (msr_read ? ucrm_pkg::RESET_NIBBLE : st.delta)
                      | (st.m_s2 ^ st.m_s3);
      if (i_wr) begin
         unique case (i_addr)
            ucrm_pkg::ADDR_HOLD: begin
               if (bank_norm) begin
                  next_st.tx_load = 1'b1;
                  next_st.tx_data = i_wdata;
               end else if (bank_div) begin
                  next_st.div_lo = i_wdata;
               end
            end
            ucrm_pkg::ADDR_IEN: begin
               if (bank_norm) begin
                  next_st.ien = i_wdata;
               end else if (bank_div) begin
                  next_st.div_hi = i_wdata;
               end
            end
            ucrm_pkg::ADDR_ISTAT: begin
               if (bank_enh) begin
                  next_st.efn = i_wdata;
               end else if (bank_norm) begin
                  next_st.fctl = i_wdata;
                  next_st.fifo_write = 1'b1;
               end else if (ext_on) begin
                  next_st.div_fr = i_wdata;
               end
            end
            ucrm_pkg::ADDR_LCTL: next_st.lctl = i_wdata;
            ucrm_pkg::ADDR_MCTL: begin
               if (bank_enh) begin
                  next_st.resume1 = i_wdata;
               end else begin
                  next_st.mctl = i_wdata;
               end
            end
            ucrm_pkg::ADDR_LSTAT: begin
               if (bank_enh) begin
                  next_st.resume2 = i_wdata;
               end
            end
            ucrm_pkg::ADDR_MSTAT: begin
               if (bank_enh) begin
                  next_st.stop1 = i_wdata;
               end else if (alt_67) begin
                  next_st.halt_lv = i_wdata;
               end
            end
            ucrm_pkg::ADDR_SCRATCH: begin
               if (bank_enh) begin
                  next_st.stop2 = i_wdata;
               end else if (alt_67) begin
                  next_st.trig_lv = i_wdata;
               end else begin
                  next_st.scratch = i_wdata;
               end
            end
            ucrm_pkg::ADDR_PINDIR: next_st.pin_dir = i_wdata;
            ucrm_pkg::ADDR_PINSTATE: begin
               if (bank_norm) begin
                  next_st.pin_out = i_wdata;
               end
            end
            ucrm_pkg::ADDR_PININT: begin
               if (bank_norm) begin
                  next_st.pin_ien = i_wdata;
               end
            end
            ucrm_pkg::ADDR_PINCTL: next_st.pin_ctl = i_wdata;
            ucrm_pkg::ADDR_EXTRA: next_st.extra = i_wdata;
            default: next_st.rdata = next_st.rdata;
         endcase
      end
      // Extended bits hold zero whenever the enhanced enable is clear
      ext_keep = next_st.efn[ucrm_pkg::EFN_EXT_EN] ? 8'hFF : 8'h00;
      mctl_keep = ~(ucrm_pkg::EXT_MCTL_MASK & ~ext_keep);
      if (!IS_CHANNEL_B) begin
         mctl_keep = mctl_keep & ~ucrm_pkg::IR_MCTL_MASK;
      end
      next_st.ien = next_st.ien & ~(ucrm_pkg::EXT_IEN_MASK & ~ext_keep);
      next_st.fctl = next_st.fctl & ~(ucrm_pkg::EXT_FCTL_MASK & ~ext_keep);
      next_st.mctl = next_st.mctl & mctl_keep;
   end

   always_ff @(posedge i_clk or negedge rst_sync) begin
      if (!rst_sync) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign o_rdata = st.rdata;
   assign o_rx_pop = st.rx_pop;
   assign o_tx_load = st.tx_load;
   assign o_tx_data = st.tx_data;
   assign o_gpio_out = st.pin_out;
   assign o_gpio_oe = st.pin_dir;
   assign o_fifo_write = st.fifo_write;
   assign o_fifo_ctrl = st.fctl;
   assign o_int_enable = st.ien;
   assign o_line_control = st.lctl;
   assign o_modem_control = st.mctl;
   assign o_divisor_low = st.div_lo;
   assign o_divisor_high = st.div_hi;
   assign o_divisor_fraction = st.div_fr;
   assign o_enhanced_function = st.efn;
   assign o_resume_char1 = st.resume1;
   assign o_resume_char2 = st.resume2;
   assign o_stop_char1 = st.stop1;
   assign o_stop_char2 = st.stop2;
   assign o_halt_resume_levels = st.halt_lv;
   assign o_fifo_trigger_levels = st.trig_lv;
   assign o_pin_interrupt_enable = st.pin_ien;
   assign o_pin_control = st.pin_ctl;
   assign o_extra_features = st.extra;

   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (!rst_sync);

   sequence s_enh_write;
      i_wr && (i_addr == ucrm_pkg::ADDR_MCTL) && bank_enh;
   endsequence
   sequence s_msr_quiet_read;
      i_rd && !i_wr && (i_addr == ucrm_pkg::ADDR_MSTAT) && !bank_enh && !alt_67
         && (st.m_s2 == st.m_s3);
   endsequence

   chk_tx_load_data: assert property (
      (i_wr && i_addr == ucrm_pkg::ADDR_HOLD && bank_norm)
         |=> (o_tx_load && o_tx_data == $past(i_wdata))
             ##1 (!o_tx_load || $past(i_wr && i_addr == ucrm_pkg::ADDR_HOLD && bank_norm)))
      else $error("transmit byte not loaded");
   chk_divisor_high: assert property (
      (i_wr && i_addr == ucrm_pkg::ADDR_IEN && bank_div)
         |=> o_divisor_high == $past(i_wdata) && o_int_enable == $past(o_int_enable))
      else $error("divisor high byte wrong");
   chk_fraction_gate: assert property (
      (i_wr && i_addr == ucrm_pkg::ADDR_ISTAT && bank_div && !ext_on)
         |=> $stable(o_divisor_fraction) && !o_fifo_write)
      else $error("fraction divisor written while locked");
   chk_status_fifo_bits: assert property (
      (i_rd && i_addr == ucrm_pkg::ADDR_ISTAT && bank_norm)
         |=> o_rdata[7:6] == {2{$past(o_fifo_ctrl[0])}} && o_rdata[3:0] == $past(i_int_source[3:0]))
      else $error("interrupt status readback wrong");
   chk_ext_bits_zero: assert property (
      !o_enhanced_function[4]
         |-> (o_int_enable[7:4] == 4'h0) && (o_modem_control[7:5] == 3'h0)
             && (o_fifo_ctrl[5:4] == 2'h0))
      else $error("extended bits set while disabled");
   chk_line_ctl_write: assert property (
      (i_wr && i_addr == ucrm_pkg::ADDR_LCTL) |=> o_line_control == $past(i_wdata))
      else $error("line control not written");
   chk_line_stat_read: assert property (
      (i_rd && i_addr == ucrm_pkg::ADDR_LSTAT && !bank_enh) |=> o_rdata == $past(i_line_status))
      else $error("line status readback wrong");
   chk_msr_clear: assert property (
      s_msr_quiet_read |=> st.delta == 4'h0)
      else $error("modem change flags not cleared");
   chk_level_msb_zero: assert property (
      (i_rd && (i_addr == ucrm_pkg::ADDR_TXSPACE || i_addr == ucrm_pkg::ADDR_RXFILL))
         |=> o_rdata[7] == 1'b0)
      else $error("fifo level bit 7 set");
   chk_resume_map: assert property (
      s_enh_write |=> o_resume_char1 == $past(i_wdata) && $stable(o_modem_control))
      else $error("enhanced bank write misrouted");
   chk_reserved_zero: assert property (
      (i_rd && i_addr == ucrm_pkg::ADDR_RSVD) |=> o_rdata == 8'h00)
      else $error("reserved address reads nonzero");
   chk_alt_select: assert property (
      (i_rd && i_addr == ucrm_pkg::ADDR_MSTAT && !bank_enh && alt_67)
         |=> o_rdata == $past(o_halt_resume_levels))
      else $error("threshold register not selected");

   // Further register and pulse checks
   sequence s_pin_change;
      st.m_s2 != st.m_s3;
   endsequence

   chk_rx_pop_pulse: assert property (
      (i_rd && i_addr == ucrm_pkg::ADDR_HOLD && bank_norm)
         |=> o_rx_pop && o_rdata == $past(i_rx_data))
      else $error("receive byte not popped");
   chk_fifo_ctl_write: assert property (
      (i_wr && i_addr == ucrm_pkg::ADDR_ISTAT && bank_norm)
         |=> o_fifo_write && o_fifo_ctrl[3:0] == $past(i_wdata[3:0]))
      else $error("fifo control not written");
   chk_scratch_write: assert property (
      (i_wr && i_addr == ucrm_pkg::ADDR_SCRATCH && !bank_enh && !alt_67)
         |=> st.scratch == $past(i_wdata))
      else $error("scratch byte not written");
   chk_ir_channel_b: assert property (
      IS_CHANNEL_B || !o_modem_control[ucrm_pkg::MCTL_IR_EN])
      else $error("infrared enabled on channel A");
   chk_pin_dir_write: assert property (
      (i_wr && i_addr == ucrm_pkg::ADDR_PINDIR) |=> o_gpio_oe == $past(i_wdata))
      else $error("pin direction not written");
   chk_change_flag_set: assert property (
      s_pin_change |=> (st.delta & $past(st.m_s2 ^ st.m_s3)) == $past(st.m_s2 ^ st.m_s3))
      else $error("modem change flag lost");
endmodule

// ### ucrm_pkg.sv
// Shared constants and state type for the UART channel register map
package ucrm_pkg;
   localparam logic [3:0] ADDR_HOLD = 4'h0;
   localparam logic [3:0] ADDR_IEN = 4'h1;
   localparam logic [3:0] ADDR_ISTAT = 4'h2;
   localparam logic [3:0] ADDR_LCTL = 4'h3;
   localparam logic [3:0] ADDR_MCTL = 4'h4;
   localparam logic [3:0] ADDR_LSTAT = 4'h5;
   localparam logic [3:0] ADDR_MSTAT = 4'h6;
   localparam logic [3:0] ADDR_SCRATCH = 4'h7;
   localparam logic [3:0] ADDR_TXSPACE = 4'h8;
   localparam logic [3:0] ADDR_RXFILL = 4'h9;
   localparam logic [3:0] ADDR_PINDIR = 4'hA;
   localparam logic [3:0] ADDR_PINSTATE = 4'hB;
   localparam logic [3:0] ADDR_PININT = 4'hC;
   localparam logic [3:0] ADDR_RSVD = 4'hD;
   localparam logic [3:0] ADDR_PINCTL = 4'hE;
   localparam logic [3:0] ADDR_EXTRA = 4'hF;
   localparam logic [7:0] LCTL_ENHANCED = 8'hBF;
   localparam int LCTL_DIV_EN = 7;
   localparam int EFN_EXT_EN = 4;
   localparam int MCTL_TCR_EN = 2;
   localparam int MCTL_IR_EN = 6;
   localparam int FCTL_FIFO_EN = 0;
   localparam logic [7:0] EXT_IEN_MASK = 8'hF0;
   localparam logic [7:0] EXT_ISTAT_MASK = 8'h30;
   localparam logic [7:0] EXT_FCTL_MASK = 8'h30;
   localparam logic [7:0] EXT_MCTL_MASK = 8'hE0;
   localparam logic [7:0] IR_MCTL_MASK = 8'h40;
   localparam logic [7:0] RESET_BYTE = 8'h00;
   localparam logic [3:0] RESET_NIBBLE = 4'h0;

   typedef struct packed {
      logic [7:0] rdata;
      logic rx_pop;
      logic tx_load;
      logic [7:0] tx_data;
      logic fifo_write;
      logic [7:0] fctl;
      logic [7:0] ien;
      logic [7:0] lctl;
      logic [7:0] mctl;
      logic [7:0] div_lo;
      logic [7:0] div_hi;
      logic [7:0] div_fr;
      logic [7:0] efn;
      logic [7:0] resume1;
      logic [7:0] resume2;
      logic [7:0] stop1;
      logic [7:0] stop2;
      logic [7:0] scratch;
      logic [7:0] halt_lv;
      logic [7:0] trig_lv;
      logic [7:0] pin_dir;
      logic [7:0] pin_out;
      logic [7:0] pin_ien;
      logic [7:0] pin_ctl;
      logic [7:0] extra;
      logic [3:0] delta;
      logic [3:0] m_s1;
      logic [3:0] m_s2;
      logic [3:0] m_s3;
      logic [7:0] g_s1;
      logic [7:0] g_s2;
   } ucrm_state_s;
endpackage

// ### ucrm_core_model.sv
// Behavioural stand-in for the UART core behind the register bank
`timescale 1ns/100ps
module ucrm_core_model (
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic i_rx_pop,
   input wire logic i_tx_load,
   input wire logic [3:0] i_pins_n,
   output logic [7:0] o_rx_data,
   output logic [5:0] o_int_source,
   output logic [7:0] o_line_status,
   output logic [6:0] o_tx_space,
   output logic [6:0] o_rx_fill,
   output logic o_cts_n,
   output logic o_dsr_n,
   output logic o_ring_in_n,
   output logic o_carrier_detect_in_n
);
   // Receive byte steps on each pop, transmit space shrinks on each load
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_rx_data <= 8'h40;
         o_tx_space <= 7'h40;
      end else begin
         if (i_rx_pop) begin
            o_rx_data <= o_rx_data + 8'h01;
         end
         if (i_tx_load) begin
            o_tx_space <= o_tx_space - 7'h01;
         end
      end
   end
   assign o_int_source = 6'h3C;
   assign o_line_status = 8'h61;
   assign o_rx_fill = 7'h7F;
   assign {o_carrier_detect_in_n, o_ring_in_n, o_dsr_n, o_cts_n} = i_pins_n;
endmodule

// ### ucrm_top_tb.sv
// Self-checking bench for the UART channel register bank
`timescale 1ns/100ps
module ucrm_top_tb;
   logic i_clk = 1'b0;
   logic i_rst_n = 1'b0;
   logic [3:0] i_addr = 4'h0;
   logic i_wr = 1'b0;
   logic i_rd = 1'b0;
   logic [7:0] i_wdata = 8'h00;
   logic [3:0] pins_n = 4'hF;
   logic [7:0] gpio_in = 8'h00;
   logic [7:0] rdata, tx_data, gpio_out, gpio_oe, fifo_ctrl, int_enable, line_control;
   logic [7:0] modem_control, div_lo, div_hi, div_fr, efn, resume1, stop2, trig, extra;
   logic [7:0] resume2, stop1, halt_lv, pin_ien, pin_ctl;
   logic rx_pop, tx_load, fifo_write, cts_n, dsr_n, ri_n, cd_n;
   logic [7:0] rx_data, line_status;
   logic [5:0] int_source;
   logic [6:0] tx_space, rx_fill;
   int err_total = 0;
   int cmp_count = 0;
   int cycles = 0;

   always #50 i_clk = ~i_clk;

   ucrm_core_model core (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_rx_pop(rx_pop),
      .i_tx_load(tx_load), .i_pins_n(pins_n), .o_rx_data(rx_data), .o_int_source(int_source),
      .o_line_status(line_status), .o_tx_space(tx_space), .o_rx_fill(rx_fill),
      .o_cts_n(cts_n), .o_dsr_n(dsr_n), .o_ring_in_n(ri_n), .o_carrier_detect_in_n(cd_n));

   ucrm_top DUT (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_addr(i_addr), .i_wr(i_wr), .i_rd(i_rd),
      .i_wdata(i_wdata), .o_rdata(rdata), .i_rx_data(rx_data), .o_rx_pop(rx_pop),
      .o_tx_load(tx_load), .o_tx_data(tx_data), .i_int_source(int_source),
      .i_line_status(line_status), .i_tx_space(tx_space), .i_rx_fill(rx_fill),
      .i_cts_n(cts_n), .i_dsr_n(dsr_n), .i_ring_in_n(ri_n), .i_carrier_detect_in_n(cd_n),
      .i_gpio_in(gpio_in), .o_gpio_out(gpio_out), .o_gpio_oe(gpio_oe),
      .o_fifo_write(fifo_write), .o_fifo_ctrl(fifo_ctrl), .o_int_enable(int_enable),
      .o_line_control(line_control), .o_modem_control(modem_control),
      .o_divisor_low(div_lo), .o_divisor_high(div_hi), .o_divisor_fraction(div_fr),
      .o_enhanced_function(efn), .o_resume_char1(resume1), .o_resume_char2(resume2),
      .o_stop_char1(stop1), .o_stop_char2(stop2), .o_halt_resume_levels(halt_lv),
      .o_fifo_trigger_levels(trig), .o_pin_interrupt_enable(pin_ien), .o_pin_control(pin_ctl),
      .o_extra_features(extra));

   task automatic tally_and_finish();
      $display("Comparisons %0d, mismatches %0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   // Guards against a hang
   always @(posedge i_clk) begin
      cycles++;
      if (cycles == 5000) begin
         err_total++;
         tally_and_finish();
      end
   end

   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      cmp_count++;
      if (got !== exp) begin
         err_total++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge i_clk);
      i_wr <= 1'b1;
      i_addr <= a;
      i_wdata <= d;
      @(posedge i_clk);
      i_wr <= 1'b0;
      #1;
   endtask

   task automatic rd(input logic [3:0] a, output logic [7:0] v);
      @(posedge i_clk);
      i_rd <= 1'b1;
      i_addr <= a;
      @(posedge i_clk);
      i_rd <= 1'b0;
      #1;
      v = rdata;
   endtask

   task automatic rdchk(input logic [3:0] a, input logic [7:0] exp);
      logic [7:0] v;
      rd(a, v);
      check(v, exp);
   endtask

   initial begin
      logic [7:0] e;
      repeat (12) @(posedge i_clk);
      i_rst_n <= 1'b1;
      repeat (3) @(posedge i_clk);
      rdchk(4'h3, 8'h00);
      wr(4'h3, 8'h1B);
      rdchk(4'h3, 8'h1B);
      check(line_control, 8'h1B);
      $display("line control test done");
      rdchk(4'h0, 8'h40);
      check({7'h00, rx_pop}, 8'h01);
      rdchk(4'h0, 8'h41);
      wr(4'h0, 8'hA5);
      check({7'h00, tx_load}, 8'h01);
      check(tx_data, 8'hA5);
      @(posedge i_clk);
      #1;
      check({7'h00, tx_load}, 8'h00);
      $display("holding test done");
      wr(4'h3, 8'h83);
      wr(4'h0, 8'h12);
      wr(4'h1, 8'h34);
      rdchk(4'h0, 8'h12);
      check(div_lo, 8'h12);
      rdchk(4'h1, 8'h34);
      check(div_hi, 8'h34);
      wr(4'h2, 8'h07);
      rdchk(4'h2, 8'h00);
      check(div_fr, 8'h00);
      rdchk(4'hB, 8'h00);
      $display("divisor test done");
      wr(4'h3, 8'hBF);
      wr(4'h2, 8'h10);
      rdchk(4'h2, 8'h10);
      check(efn, 8'h10);
      for (int a = 4; a < 8; a++) begin
         wr(4'(a), 8'hC0 + 8'(a));
         rdchk(4'(a), 8'hC0 + 8'(a));
      end
      check(resume1, 8'hC4);
      check(stop2, 8'hC7);
      check(resume2, 8'hC5);
      check(stop1, 8'hC6);
      rdchk(4'h0, 8'h00);
      wr(4'h3, 8'h80);
      wr(4'h2, 8'h09);
      rdchk(4'h2, 8'h09);
      check(div_fr, 8'h09);
      $display("enhanced bank test done");
      wr(4'h3, 8'h03);
      wr(4'h1, 8'hFF);
      rdchk(4'h1, 8'hFF);
      check(int_enable, 8'hFF);
      wr(4'h2, 8'hF1);
      check({7'h00, fifo_write}, 8'h01);
      check(fifo_ctrl, 8'hF1);
      rdchk(4'h2, 8'hFC);
      wr(4'h4, 8'hE4);
      rdchk(4'h4, 8'hA4);
      check(modem_control, 8'hA4);
      wr(4'h6, 8'h5A);
      rdchk(4'h6, 8'h5A);
      check(halt_lv, 8'h5A);
      wr(4'h7, 8'hC3);
      rdchk(4'h7, 8'hC3);
      wr(4'h4, 8'h00);
      wr(4'h7, 8'h66);
      rdchk(4'h7, 8'h66);
      check(trig, 8'hC3);
      wr(4'h3, 8'hBF);
      wr(4'h2, 8'h00);
      wr(4'h3, 8'h03);
      rdchk(4'h1, 8'h0F);
      check(fifo_ctrl, 8'hC1);
      rdchk(4'h2, 8'hCC);
      $display("extended bits test done");
      rdchk(4'h5, 8'h61);
      rdchk(4'h8, 8'h3F);
      rdchk(4'h9, 8'h7F);
      rdchk(4'h6, 8'h00);
      for (int i = 0; i < 4; i++) begin
         @(posedge i_clk);
         pins_n[i] <= 1'b0;
         repeat (4) @(posedge i_clk);
         #1;
         e = {~pins_n, 4'h0} | (8'h01 << i);
         rdchk(4'h6, e);
         rdchk(4'h6, e & 8'hF0);
      end
      $display("status test done");
      wr(4'hA, 8'hF0);
      check(gpio_oe, 8'hF0);
      rdchk(4'hA, 8'hF0);
      wr(4'hB, 8'hA5);
      check(gpio_out, 8'hA5);
      @(posedge i_clk);
      gpio_in <= 8'h3C;
      repeat (4) @(posedge i_clk);
      rdchk(4'hB, 8'hAC);
      wr(4'hC, 8'h55);
      rdchk(4'hC, 8'h55);
      check(pin_ien, 8'h55);
      wr(4'hD, 8'hFF);
      rdchk(4'hD, 8'h00);
      wr(4'hE, 8'h0B);
      rdchk(4'hE, 8'h0B);
      check(pin_ctl, 8'h0B);
      wr(4'hF, 8'h86);
      rdchk(4'hF, 8'h86);
      check(extra, 8'h86);
      $display("pin register test done");
      @(posedge i_clk);
      i_rst_n <= 1'b0;
      repeat (3) @(posedge i_clk);
      i_rst_n <= 1'b1;
      repeat (3) @(posedge i_clk);
      rdchk(4'h3, 8'h00);
      check(extra, 8'h00);
      check(gpio_oe, 8'h00);
      $display("reset test done");
      tally_and_finish();
   end
endmodule
